// *** hdl/rtcc_pkg.sv ***
// constants shared by the real-time clock and calendar core
// Notes on behaviour
// (RULE_01) eight BCD bytes hold time and calendar
// (RULE_02) seventeen status and control bytes follow
// (RULE_03) seven user bytes survive power loss
// (RULE_04) pointer steps after every data byte
// (RULE_05) century to hundredths, 24-hour hours
// (RULE_06) month lengths and leap February automatic
// (RULE_07) programmable square wave, 32 kHz default
// (RULE_08) one open-drain pin, three shared uses
// (RULE_09) open-drain reset output held at power-on
// (RULE_10) first bit direction, then seven-bit address; the code loads only the low six into the pointer
// (RULE_11) sample on rise, shift after fall
// (RULE_12) pointer wraps to zero past top
// (RULE_13) time copy frozen while clock addressed
// (RULE_14) deselect ends transfer, expects direction bit
package rtcc_pkg;
    // clock rates
    localparam int unsigned CLK_HZ      = 20_000_000;   // system clock rate
    localparam int unsigned HUND_HZ     = 100;          // hundredths tick rate
    localparam int unsigned SQW_BASE_HZ = 65_536;       // twice the top square wave rate
    // power-on reset output hold time
    localparam int unsigned RST_HOLD_US = 100;
    localparam int unsigned RST_HOLD_CYC = (RST_HOLD_US * (CLK_HZ / 1_000_000));
    // byte map
    localparam logic [5:0] ADDR_TIME_LAST = 6'h07;     // last timekeeping byte
    localparam logic [5:0] ADDR_CTRL_BASE = 6'h08;     // first status/control byte
    localparam logic [5:0] ADDR_RAM_BASE  = 6'h19;     // first user memory byte
    localparam logic [5:0] ADDR_MAP_LAST  = 6'h1F;     // last mapped byte
    localparam int unsigned CTRL_BYTES    = 17;
    localparam int unsigned RAM_BYTES     = 7;
    // control byte indices, relative to ADDR_CTRL_BASE
    localparam logic [4:0] IDX_OUTCTL = 5'h00;         // output pin control
    localparam logic [4:0] IDX_ALM_EN = 5'h02;         // alarm enable
    localparam logic [4:0] IDX_ALM_HR = 5'h04;         // alarm hour
    localparam logic [4:0] IDX_ALM_MN = 5'h05;         // alarm minute
    localparam logic [4:0] IDX_ALM_SC = 5'h06;         // alarm second
    localparam logic [4:0] IDX_FLAGS  = 5'h07;         // flags
    localparam logic [4:0] IDX_SQW    = 5'h0B;         // square wave select
    // field positions
    localparam int unsigned BIT_OUT   = 7;             // output level bit
    localparam int unsigned BIT_FT    = 6;             // frequency test enable
    localparam int unsigned BIT_AFE   = 7;             // alarm interrupt enable
    localparam int unsigned BIT_AF    = 6;             // alarm flag
    localparam int unsigned BIT_FT_TAP = 6;            // divider tap for 512 Hz
    localparam logic [7:0] SQW_RESET  = 8'h01;         // select 32 kHz
    localparam logic [7:0] OUTCTL_RESET = 8'h80;       // pin released
    // BCD limits
    localparam logic [7:0] HUND_MAX  = 8'h99;
    localparam logic [7:0] SEC_MAX   = 8'h59;
    localparam logic [5:0] HOUR_MAX  = 6'h23;
    localparam logic [2:0] WDAY_MAX  = 3'h7;
    localparam logic [2:0] WDAY_MIN  = 3'h1;
    localparam logic [7:0] MONTH_MAX = 8'h12;
    localparam logic [7:0] YEAR_MAX  = 8'h99;
    localparam logic [7:0] DAY_ONE   = 8'h01;
    localparam logic [7:0] BCD_ZERO  = 8'h00;
    localparam logic [7:0] MON_FEB   = 8'h02;
    localparam logic [7:0] MON_APR   = 8'h04;
    localparam logic [7:0] MON_JUN   = 8'h06;
    localparam logic [7:0] MON_SEP   = 8'h09;
    localparam logic [7:0] MON_NOV   = 8'h11;
    localparam logic [7:0] LAST_28   = 8'h28;
    localparam logic [7:0] LAST_29   = 8'h29;
    localparam logic [7:0] LAST_30   = 8'h30;
    localparam logic [7:0] LAST_31   = 8'h31;
    // serial states
    typedef enum logic [1:0] {RTCC_IDLE, RTCC_HDR, RTCC_WR, RTCC_RD} rtcc_state_t;
endpackage

// *** hdl/rtcc_time_core.sv ***
// BCD time and calendar counter chain
`timescale 1ns/1ps
`default_nettype none
module rtcc_time_core
    import rtcc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        tick_100hz,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_addr,
    input  wire logic [7:0]  wr_data,
    output logic      [63:0] time_q,
    output logic             sec_pulse
);
    logic [7:0] t_q [8];     // live time bytes
    logic [7:0] yr;          // year byte
    logic       leap;        // year divisible by four
    logic [7:0] last_day;    // last date of this month
    logic [7:0] hr_inc;      // hour field stepped in BCD

    // one BCD step of a two-digit byte
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction

    // next hour value, kept apart so its low six bits can be selected
    assign hr_inc = bcd_inc({2'b00, t_q[3][5:0]});

    // flatten bytes onto the output
    for (genvar i = 0; i < 8; i++) begin : g_out
        assign time_q[8*i +: 8] = t_q[i];
    end

    // leap year and month length lookup
    assign yr = t_q[7];
    always_comb begin
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        if (t_q[6] == MON_FEB) begin
            last_day = leap ? LAST_29 : LAST_28;                 // [RULE_06]
        end else if (t_q[6] == MON_APR || t_q[6] == MON_JUN ||
                     t_q[6] == MON_SEP || t_q[6] == MON_NOV) begin
            last_day = LAST_30;                                  // [RULE_06]
        end else begin
            last_day = LAST_31;
        end
    end

    // counter cascade; a software write takes priority over the tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                t_q[i] <= BCD_ZERO;
            end
            t_q[4] <= DAY_ONE;
            t_q[5] <= DAY_ONE;
            t_q[6] <= DAY_ONE;
        end else if (wr_en) begin
            t_q[wr_addr] <= wr_data;                             // [RULE_01]
        end else if (tick_100hz) begin
            if (t_q[0] != HUND_MAX) begin
                t_q[0] <= bcd_inc(t_q[0]);                       // [RULE_05]
            end else begin
                t_q[0] <= BCD_ZERO;
                if (t_q[1] != SEC_MAX) begin
                    t_q[1] <= bcd_inc(t_q[1]);
                end else begin
                    t_q[1] <= BCD_ZERO;
                    if (t_q[2] != SEC_MAX) begin
                        t_q[2] <= bcd_inc(t_q[2]);
                    end else begin
                        t_q[2] <= BCD_ZERO;
                        if (t_q[3][5:0] != HOUR_MAX) begin
                            t_q[3] <= {t_q[3][7:6], hr_inc[5:0]};    // [RULE_05]
                        end else begin
                            // new day
                            t_q[4][2:0] <= (t_q[4][2:0] == WDAY_MAX) ? WDAY_MIN
                                                                     : t_q[4][2:0] + 3'h1;
                            if (t_q[5] != last_day) begin
                                t_q[5] <= bcd_inc(t_q[5]);
                                t_q[3] <= {t_q[3][7:6], 6'h00};
                            end else begin
                                t_q[5] <= DAY_ONE;                       // [RULE_06]
                                if (t_q[6] != MONTH_MAX) begin
                                    t_q[6] <= bcd_inc(t_q[6]);
                                    t_q[3] <= {t_q[3][7:6], 6'h00};
                                end else begin
                                    t_q[6] <= DAY_ONE;
                                    if (t_q[7] != YEAR_MAX) begin
                                        t_q[7] <= bcd_inc(t_q[7]);
                                        t_q[3] <= {t_q[3][7:6], 6'h00};
                                    end else begin
                                        t_q[7] <= BCD_ZERO;
                                        t_q[3] <= {t_q[3][7:6] + 2'h1, 6'h00}; // [RULE_05]
                                    end
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    // one-cycle pulse at each whole second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_pulse <= 1'b0;
        end else begin
            sec_pulse <= tick_100hz && !wr_en && (t_q[0] == HUND_MAX);
        end
    end
endmodule
`default_nettype wire

// *** hdl/rtcc_top.sv ***
// serial-bus real-time clock top: interface, byte map and output pins
`timescale 1ns/1ps
`default_nettype none
module rtcc_top (
    input  wire logic CLK_SYS,
    input  wire logic RST_N,
    input  wire logic SPI_SCL,
    input  wire logic SPI_CS_N,
    input  wire logic SERIAL_IN,
    output logic      SERIAL_OUT,
    output logic      SERIAL_OUT_OE_N,
    output logic      SQUARE_WAVE_OUT,
    output logic      SHARED_INTERRUPT_OUTPUT,
    output logic      SHARED_INTERRUPT_OUTPUT_OE_N,
    output logic      RESET_OUT,
    output logic      RESET_OUT_OE_N
);
    import rtcc_pkg::*;

    logic [2:0]  scl_s_q;          // scl synchroniser and edge history
    logic [1:0]  cs_s_q;           // chip select synchroniser
    logic [1:0]  sdi_s_q;          // data in synchroniser
    logic        scl_rise;         // sampled rising edge
    logic        scl_fall;         // sampled falling edge
    logic        cs_act;           // device selected
    rtcc_state_t state_q;          // serial state
    logic [2:0]  bit_cnt_q;        // bits taken in this byte
    logic [7:0]  rx_q;             // incoming shift register
    logic [7:0]  rx_byte;          // byte completed on this rise
    logic [7:0]  tx_q;             // outgoing shift register
    logic [5:0]  ptr_q;            // byte address pointer
    logic        wr_stb;           // completed write data byte
    logic        sdo_q;            // serial data out
    logic        sdo_oe_n_q;       // serial data out enable
    logic [7:0]  ctrl_q [CTRL_BYTES]; // status and control bytes
    logic [7:0]  ram_q  [RAM_BYTES];  // user memory, no reset
    logic [4:0]  cidx;             // pointer relative to control base
    logic [4:0]  ridx;             // pointer relative to ram base
    logic [63:0] live_time;        // running time bytes
    logic [63:0] snap_q;           // user-visible time copy
    logic        freeze;           // hold the time copy
    logic        sec_pulse;        // whole second
    logic [7:0]  rd_byte;          // byte at the pointer
    logic [24:0] acc100_q;         // hundredths rate accumulator
    logic [24:0] accsq_q;          // square wave rate accumulator
    logic        tick100_q;        // hundredths enable
    logic        ticksq_q;         // 65536 Hz enable
    logic [14:0] div_q;            // square wave divider chain
    logic [3:0]  rs;               // square wave select
    logic        sqw_q;            // square wave out
    logic        alm_match;        // alarm compare
    logic        irq_act;          // interrupt asserted
    logic        pin_oe_n_q;       // shared pin enable, low pulls the pin
    logic [$clog2(RST_HOLD_CYC+1)-1:0] por_cnt_q; // power-on hold counter
    logic        rst_oe_n_q;       // reset output enable, low asserts reset

    // input synchronisers; first stages feed only second stages
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            scl_s_q <= 3'b000;
            cs_s_q  <= 2'b11;
            sdi_s_q <= 2'b00;
        end else begin
            scl_s_q <= {scl_s_q[1:0], SPI_SCL};
            cs_s_q  <= {cs_s_q[0], SPI_CS_N};
            sdi_s_q <= {sdi_s_q[0], SERIAL_IN};
        end
    end
    assign scl_rise = cs_act && scl_s_q[1] && !scl_s_q[2];   // [RULE_11]
    assign scl_fall = cs_act && !scl_s_q[1] && scl_s_q[2];   // [RULE_11]
    assign cs_act   = !cs_s_q[1];
    assign rx_byte  = {rx_q[6:0], sdi_s_q[1]};

    // serial state, bit counter and receive shift
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state_q   <= RTCC_IDLE;
            bit_cnt_q <= 3'h0;
            rx_q      <= 8'h00;
        end else if (!cs_act) begin
            state_q   <= RTCC_IDLE;                            // [RULE_14]
            bit_cnt_q <= 3'h0;
        end else if (state_q == RTCC_IDLE) begin
            state_q   <= RTCC_HDR;                             // fresh selection
        end else if (scl_rise) begin
            rx_q      <= rx_byte;                              // [RULE_11]
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7 && state_q == RTCC_HDR) begin
                state_q <= rx_byte[7] ? RTCC_WR : RTCC_RD;     // [RULE_10]
            end
        end
    end
    assign wr_stb = scl_rise && state_q == RTCC_WR && bit_cnt_q == 3'h7;

    // address pointer: loaded from header, stepped per byte, wraps
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ptr_q <= 6'h00;
        end else if (scl_rise && state_q == RTCC_HDR && bit_cnt_q == 3'h7) begin
            ptr_q <= rx_byte[5:0];                             // [RULE_10]
        end else if (wr_stb || (scl_fall && state_q == RTCC_RD && bit_cnt_q == 3'h0)) begin
            ptr_q <= ptr_q + 6'h01;                            // [RULE_04] [RULE_12]
        end
    end

    // read data mux over the byte map
    assign cidx = 5'(ptr_q - ADDR_CTRL_BASE);
    assign ridx = 5'(ptr_q - ADDR_RAM_BASE);
    always_comb begin
        if (ptr_q <= ADDR_TIME_LAST) begin
            rd_byte = snap_q[8*ptr_q[2:0] +: 8];               // [RULE_01]
        end else if (ptr_q < ADDR_RAM_BASE) begin
            rd_byte = ctrl_q[cidx];                            // [RULE_02]
        end else if (ptr_q <= ADDR_MAP_LAST) begin
            rd_byte = ram_q[ridx[2:0]];                        // [RULE_03]
        end else begin
            rd_byte = 8'h00;                                   // unmapped upper half
        end
    end

    // transmit: new byte on the fall after each byte boundary
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            tx_q       <= 8'h00;
            sdo_q      <= 1'b0;
            sdo_oe_n_q <= 1'b1;
        end else if (state_q != RTCC_RD) begin
            sdo_oe_n_q <= 1'b1;                                // released when not reading
        end else if (scl_fall) begin
            sdo_oe_n_q <= 1'b0;
            if (bit_cnt_q == 3'h0) begin
                sdo_q <= rd_byte[7];                           // [RULE_11]
                tx_q  <= {rd_byte[6:0], 1'b0};
            end else begin
                sdo_q <= tx_q[7];                              // [RULE_11]
                tx_q  <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // time counter chain
    rtcc_time_core u_time (
        .clk        (CLK_SYS),
        .rst_n      (RST_N),
        .tick_100hz (tick100_q),
        .wr_en      (wr_stb && ptr_q <= ADDR_TIME_LAST),
        .wr_addr    (ptr_q[2:0]),
        .wr_data    (rx_byte),
        .time_q     (live_time),
        .sec_pulse  (sec_pulse)
    );

    // user copy follows the live time unless the clock bytes are addressed
    assign freeze = cs_act && (state_q == RTCC_WR || state_q == RTCC_RD)
                    && ptr_q <= ADDR_TIME_LAST;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            snap_q <= 64'h0000_0000_0000_0000;
        end else if (!freeze) begin
            snap_q <= live_time;                               // [RULE_13]
        end
    end

    // status and control bytes; alarm flag set wins over a write
    assign alm_match = sec_pulse && live_time[8 +: 8] == ctrl_q[IDX_ALM_SC]
                       && live_time[16 +: 8] == ctrl_q[IDX_ALM_MN]
                       && live_time[24 +: 6] == ctrl_q[IDX_ALM_HR][5:0];
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < CTRL_BYTES; i++) begin
                ctrl_q[i] <= 8'h00;
            end
            ctrl_q[IDX_SQW]    <= SQW_RESET;                   // [RULE_07]
            ctrl_q[IDX_OUTCTL] <= OUTCTL_RESET;
        end else begin
            if (wr_stb && ptr_q >= ADDR_CTRL_BASE && ptr_q < ADDR_RAM_BASE) begin
                ctrl_q[cidx] <= rx_byte;                       // [RULE_02]
            end
            if (alm_match) begin
                ctrl_q[IDX_FLAGS][BIT_AF] <= 1'b1;
            end
        end
    end

    // user memory keeps its content through reset
    always_ff @(posedge CLK_SYS) begin
        if (wr_stb && ptr_q >= ADDR_RAM_BASE && ptr_q <= ADDR_MAP_LAST) begin
            ram_q[ridx[2:0]] <= rx_byte;                       // [RULE_03]
        end
    end

    // rate accumulators for hundredths and square wave base
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            acc100_q  <= 25'h0;
            accsq_q   <= 25'h0;
            tick100_q <= 1'b0;
            ticksq_q  <= 1'b0;
        end else begin
            tick100_q <= acc100_q >= 25'(CLK_HZ - HUND_HZ);
            acc100_q  <= (acc100_q >= 25'(CLK_HZ - HUND_HZ)) ?
                         25'(acc100_q + HUND_HZ - CLK_HZ) : 25'(acc100_q + HUND_HZ);
            ticksq_q  <= accsq_q >= 25'(CLK_HZ - SQW_BASE_HZ);
            accsq_q   <= (accsq_q >= 25'(CLK_HZ - SQW_BASE_HZ)) ?
                         25'(accsq_q + SQW_BASE_HZ - CLK_HZ) : 25'(accsq_q + SQW_BASE_HZ);
        end
    end

    // square wave divider and select, bit k runs at 32768 >> k Hz
    assign rs = ctrl_q[IDX_SQW][3:0];
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            div_q <= 15'h0;
            sqw_q <= 1'b0;
        end else begin
            if (ticksq_q) begin
                div_q <= div_q + 15'h1;
            end
            sqw_q <= (rs == 4'h0) ? 1'b0 : div_q[4'(rs - 4'h1)]; // [RULE_07]
        end
    end

    // shared pin: interrupt first, then frequency test, then level
    assign irq_act = ctrl_q[IDX_FLAGS][BIT_AF] && ctrl_q[IDX_ALM_EN][BIT_AFE];
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pin_oe_n_q <= 1'b1;
        end else if (irq_act) begin
            pin_oe_n_q <= 1'b0;                                // [RULE_08]
        end else if (ctrl_q[IDX_OUTCTL][BIT_FT]) begin
            pin_oe_n_q <= div_q[BIT_FT_TAP];                   // [RULE_08]
        end else begin
            pin_oe_n_q <= ctrl_q[IDX_OUTCTL][BIT_OUT];         // [RULE_08]
        end
    end

    // power-on reset output hold
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            por_cnt_q  <= '0;
            rst_oe_n_q <= 1'b0;
        end else if (por_cnt_q != ($bits(por_cnt_q))'(RST_HOLD_CYC)) begin
            por_cnt_q  <= por_cnt_q + 1'b1;
            rst_oe_n_q <= 1'b0;                                // [RULE_09]
        end else begin
            rst_oe_n_q <= 1'b1;
        end
    end

    // pin outputs from flops, open-drain data levels tied low
    assign SERIAL_OUT                   = sdo_q;
    assign SERIAL_OUT_OE_N              = sdo_oe_n_q;
    assign SQUARE_WAVE_OUT              = sqw_q;
    assign SHARED_INTERRUPT_OUTPUT      = 1'b0;
    assign SHARED_INTERRUPT_OUTPUT_OE_N = pin_oe_n_q;
    assign RESET_OUT                    = 1'b0;
    assign RESET_OUT_OE_N               = rst_oe_n_q;
endmodule
`default_nettype wire

// *** testbench/rtcc_monitor.sv ***
// port checker for the real-time clock top
`timescale 1ns/1ps
`default_nettype none
module rtcc_monitor (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic SPI_SCL,
    input wire logic SPI_CS_N,
    input wire logic SERIAL_IN,
    input wire logic SERIAL_OUT,
    input wire logic SERIAL_OUT_OE_N,
    input wire logic SQUARE_WAVE_OUT,
    input wire logic SHARED_INTERRUPT_OUTPUT,
    input wire logic SHARED_INTERRUPT_OUTPUT_OE_N,
    input wire logic RESET_OUT,
    input wire logic RESET_OUT_OE_N
);
    logic [11:0] rel_cnt_q;   // cycles since reset release, saturating
    logic [9:0]  hold_cnt_q;  // cycles since last square wave edge
    logic        sqw_q;       // square wave one cycle back
    default clocking mon_cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // count cycles after release
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rel_cnt_q <= 12'h000;
        end else if (rel_cnt_q != 12'hFFF) begin
            rel_cnt_q <= rel_cnt_q + 12'h001;
        end
    end
    // measure square wave half periods
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sqw_q      <= 1'b0;
            hold_cnt_q <= 10'h000;
        end else begin
            sqw_q      <= SQUARE_WAVE_OUT;
            hold_cnt_q <= (sqw_q != SQUARE_WAVE_OUT) ? 10'h000 : hold_cnt_q + 10'h001;
        end
    end
    rst_hold_a: assert property ((rel_cnt_q < 12'd1990) |-> !RESET_OUT_OE_N)
        else $error("reset output released early");
    rst_done_a: assert property ((rel_cnt_q > 12'd2010) |-> RESET_OUT_OE_N)
        else $error("reset output held too long");
    reset_vals_a: assert property ($rose(RST_N) |-> !RESET_OUT_OE_N && SERIAL_OUT_OE_N
        && SHARED_INTERRUPT_OUTPUT_OE_N) else $error("wrong pin levels at release");
    od_data_a: assert property (!RESET_OUT && !SHARED_INTERRUPT_OUTPUT)
        else $error("open drain data not low");
    hdr_quiet_a: assert property ($fell(SPI_CS_N) |-> SERIAL_OUT_OE_N [*8])
        else $error("data out driven during header");
    hiz_end_a: assert property ($rose(SPI_CS_N) |-> ##[1:5] SERIAL_OUT_OE_N)
        else $error("data out not released on deselect");
    drive_sel_a: assert property (!SERIAL_OUT_OE_N |-> !$past(SPI_CS_N, 6))
        else $error("data out driven while deselected");
    sqw_period_a: assert property (hold_cnt_q <= 10'd310)
        else $error("square wave half period too long");
endmodule
bind rtcc_top rtcc_monitor mon_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SPI_SCL(SPI_SCL),
    .SPI_CS_N(SPI_CS_N), .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT),
    .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N), .SQUARE_WAVE_OUT(SQUARE_WAVE_OUT),
    .SHARED_INTERRUPT_OUTPUT(SHARED_INTERRUPT_OUTPUT), .RESET_OUT(RESET_OUT),
    .SHARED_INTERRUPT_OUTPUT_OE_N(SHARED_INTERRUPT_OUTPUT_OE_N), .RESET_OUT_OE_N(RESET_OUT_OE_N));
`default_nettype wire

// *** testbench/rtcc_host_model.sv ***
// serial bus master model, mode 0, paced by the system clock
`timescale 1ns/1ps
`default_nettype none
module rtcc_host_model (
    input  wire logic clk,      // paces the 400 ns link clock
    input  wire logic ser_out,  // resolved data line from device
    output logic      scl,      // link clock, still outside frames
    output logic      cs_n,     // chip select, active low
    output logic      ser_in    // data toward device
);
    // idle levels
    initial begin
        scl = 1'b0;
        cs_n = 1'b1;
        ser_in = 1'b0;
    end
    // one byte or its leading bits, msb first
    task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            ser_in = tx[i];  // set while clock low
            repeat (4) @(negedge clk);
            rx[i] = ser_out;  // device bit settled before the rise
            scl = 1'b1;
            repeat (4) @(negedge clk);
            scl = 1'b0;
        end
    endtask
    // whole access: header, n bytes, optional partial byte
    task automatic frame(input logic wr, input logic [5:0] adr, input int n, input int cut,
                         ref logic [7:0] d [8]);
        logic [7:0] rx;
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
        shift({wr, 1'b0, adr}, 8, rx);  // direction bit then address
        for (int k = 0; k < n; k++) begin
            shift(wr ? d[k] : 8'h5A, 8, rx);
            if (!wr) d[k] = rx;
        end
        if (cut > 0) shift(d[0], cut, rx);
        repeat (4) @(negedge clk);
        cs_n = 1'b1;  // deselect closes the access
        ser_in = ~ser_in;  // released line shows no stale bit
        repeat (8) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the real-time clock top
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [5:0] a; logic [7:0] w; logic [7:0] e;} rtcc_row_t;
    localparam rtcc_row_t ROWS [8] = '{
        '{6'h19, 8'h3C, 8'h3C}, '{6'h1F, 8'hC3, 8'hC3},  // user bytes
        '{6'h20, 8'hFF, 8'h00},  // unmapped reads zero
        '{6'h0C, 8'h17, 8'h17}, '{6'h0E, 8'h45, 8'h45},  // control bytes
        '{6'h02, 8'h59, 8'h59}, '{6'h03, 8'h23, 8'h23},  // minute, hour
        '{6'h07, 8'h99, 8'h99}};  // year
    logic      clk_sys = 1'b0;  // 20 MHz system clock
    logic      rst_n   = 1'b0;  // power-on reset
    wire logic spi_scl, spi_cs_n, ser_in, ser_out, so_oe_n, square_wave_out;
    wire logic irq_d, irq_oe_n, rst_d, rst_oe_n;
    wire logic sdo_line = so_oe_n ? 1'bz : ser_out;  // resolved data out wire
    int        num_errors = 0;  // mismatches
    int        n_compared = 0;  // comparisons
    logic [7:0] d [8];           // transfer buffer
    always #25 clk_sys = ~clk_sys;
    rtcc_top dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .SPI_SCL(spi_scl), .SPI_CS_N(spi_cs_n),
        .SERIAL_IN(ser_in), .SERIAL_OUT(ser_out), .SERIAL_OUT_OE_N(so_oe_n),
        .SQUARE_WAVE_OUT(square_wave_out), .SHARED_INTERRUPT_OUTPUT(irq_d),
        .SHARED_INTERRUPT_OUTPUT_OE_N(irq_oe_n), .RESET_OUT(rst_d), .RESET_OUT_OE_N(rst_oe_n));
    rtcc_host_model host_u (.clk(clk_sys), .ser_out(sdo_line), .scl(spi_scl),
        .cs_n(spi_cs_n), .ser_in(ser_in));
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic tally_and_finish();
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (80000) @(posedge clk_sys);
        num_errors++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        int   edges;
        logic prev;
        repeat (12) @(negedge clk_sys);
        check({7'h00, rst_oe_n}, 8'h00);
        check({7'h00, so_oe_n}, 8'h01);
        rst_n = 1'b1;
        repeat (1990) @(negedge clk_sys);
        check({7'h00, rst_oe_n}, 8'h00);
        repeat (20) @(negedge clk_sys);
        check({7'h00, rst_oe_n}, 8'h01);
        host_u.frame(1'b0, 6'h04, 3, 0, d);
        for (int k = 0; k < 3; k++) check(d[k], 8'h01);
        host_u.frame(1'b0, 6'h13, 1, 0, d);
        check(d[0], 8'h01);
        foreach (ROWS[i]) begin
            d[0] = ROWS[i].w;
            host_u.frame(1'b1, ROWS[i].a, 1, 0, d);
            host_u.frame(1'b0, ROWS[i].a, 1, 0, d);
            check(d[0], ROWS[i].e);
        end
        for (int v = 0; v < 2; v++) begin
            d[0] = {v[0], 7'h00};
            host_u.frame(1'b1, 6'h08, 1, 0, d);
            check({7'h00, irq_oe_n}, {7'h00, v[0]});
        end
        d[0] = 8'hFF;
        d[1] = 8'h00;
        d[2] = 8'h42;
        host_u.frame(1'b1, 6'h3F, 3, 0, d);
        host_u.frame(1'b0, 6'h01, 1, 0, d);
        check(d[0], 8'h42);
        d[0] = 8'h00;
        host_u.frame(1'b1, 6'h19, 0, 5, d);
        host_u.frame(1'b0, 6'h19, 1, 0, d);
        check(d[0], 8'h3C);
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        check({7'h00, rst_oe_n}, 8'h00);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        host_u.frame(1'b0, 6'h19, 1, 0, d);
        check(d[0], 8'h3C);
        edges = 0;
        for (int c = 0; c < 20000; c++) begin
            prev = square_wave_out;
            @(negedge clk_sys);
            if (square_wave_out && !prev) edges++;
        end
        check({7'h00, (edges == 32) || (edges == 33)}, 8'h01);
        tally_and_finish();
    end
endmodule
`default_nettype wire
